//--- verilog/dis_sequencer.sv
/*
  decoder interrupt sequencer: apb registers, command handling, play,
  scan, pause and error recovery states, display-time interrupt checks.
  assumes decoder event inputs are one-cycle pulses synchronous to
  clk_sys_in, and an apb master on the same clock.
*/
// The APB register port and the address map were decided locally.
// Functional notes
// - device drives line low only while status is zero
// - stream error starts recovery, issues error interrupt
// - events during nonzero status are queued
// - row end stores fullness, issues queued interrupts
// - coinciding conditions share one physical interrupt
// - mask command deferred until picture decode completes
// - mask argument decoded bitwise, one enable per type
// - mask bit 8 enables buffer underflow interrupt
// - recovery raises underflow/ready at every row
// - decodable picture start ends recovery, runs deferred
// - vsync before new picture raises display event
// - scan command deferred, moves play to scan
// - scan skips P/B pictures until I picture
// - scan I picture done: pause, scan-done event
// - flush runs at once, discards recent data
// - low-priority commands queue; pause runs scan quickly
// - interrupt asserted by clearing line bit low
`timescale 1ns/1ns
module dis_sequencer #(
  parameter int FIFO_DEPTH = dis_pkg::CMD_FIFO_DEPTH
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stream_error_in,
  input wire logic pic_start_in,
  input wire logic pic_is_i_in,
  input wire logic pic_decodable_in,
  input wire logic decode_done_in,
  input wire logic vsync_in,
  input wire logic first_field_in,
  input wire logic row_end_in,
  input wire logic [15:0] buffer_level_in,
  input wire logic buffer_empty_in,
  input wire logic ready_cond_in,
  output logic int_n_out,
  output logic consume_en_out,
  output logic fast_scan_out,
  output logic discard_out,
  output logic flush_stream_out,
  output logic new_packet_out,
  output logic [15:0] packet_arg_out
);
  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic [31:0] next_rdata;
  dis_pkg::dis_cmd_t wcmd;
  dis_pkg::dis_cmd_t fifo_cmd;
  logic low_prio;
  logic fifo_in_ready;
  logic fifo_valid;
  logic exec;
  logic [15:0] mask;
  logic [15:0] fullness;
  logic [15:0] status;
  logic [15:0] pending;
  dis_pkg::dis_mode_t mode;
  dis_pkg::dis_mode_t resume_mode;
  logic i_found;
  logic draining;
  logic overflow;
  logic scan_done;
  logic recover_exit;
  logic [15:0] imm_events;
  logic [15:0] row_events;

  // zero-wait slave: pready rises in every access cycle
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign wcmd = dis_pkg::dis_cmd_t'(pwdata[dis_pkg::CMD_OP_LSB+2:0]);
  assign mapped = (paddr == dis_pkg::ADDR_CTRL) ||
                  (paddr == dis_pkg::ADDR_STATUS) ||
                  (paddr == dis_pkg::ADDR_FULLNESS) ||
                  (paddr == dis_pkg::ADDR_CMD) ||
                  (paddr == dis_pkg::ADDR_MASK) ||
                  (paddr == dis_pkg::ADDR_STATE);
  assign low_prio = (wcmd.op == dis_pkg::OP_SET_MASK) ||
                    (wcmd.op == dis_pkg::OP_SCAN) ||
                    (wcmd.op == dis_pkg::OP_PLAY);

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      dis_pkg::ADDR_CTRL: begin
        next_rdata[dis_pkg::CTRL_LINE_BIT] = int_n_out;
      end
      dis_pkg::ADDR_STATUS: begin
        next_rdata[15:0] = status;
      end
      dis_pkg::ADDR_FULLNESS: begin
        next_rdata[15:0] = fullness;
      end
      dis_pkg::ADDR_MASK: begin
        next_rdata[15:0] = mask;
      end
      dis_pkg::ADDR_STATE: begin
        next_rdata[1:0] = mode;
        next_rdata[dis_pkg::STATE_DRAIN_BIT] = draining;
        next_rdata[dis_pkg::STATE_OVF_BIT] = overflow;
        next_rdata[dis_pkg::STATE_PEND_LSB+15:dis_pkg::STATE_PEND_LSB] =
          pending;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  // mask, scan and play wait in the fifo; a full fifo drops the command
  dis_fifo #(
    .WIDTH($bits(dis_pkg::dis_cmd_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(wr && paddr == dis_pkg::ADDR_CMD && low_prio),
    .in_ready_out(fifo_in_ready),
    .in_data_in(wcmd),
    .out_valid_out(fifo_valid),
    .out_ready_in(exec),
    .out_data_out(fifo_cmd)
  );

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      overflow <= 1'b0;
    end else if (wr && paddr == dis_pkg::ADDR_CMD && low_prio &&
                 !fifo_in_ready) begin
      overflow <= 1'b1;
    end else if (wr && paddr == dis_pkg::ADDR_STATE) begin
      overflow <= 1'b0;
    end
  end

  // high-priority commands act in the cycle after the write
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flush_stream_out <= 1'b0;
      new_packet_out <= 1'b0;
      packet_arg_out <= 16'h0000;
    end else begin
      flush_stream_out <= wr && paddr == dis_pkg::ADDR_CMD &&
                          wcmd.op == dis_pkg::OP_FLUSH;
      new_packet_out <= wr && paddr == dis_pkg::ADDR_CMD &&
                        wcmd.op == dis_pkg::OP_NEW_PACKET;
      if (wr && paddr == dis_pkg::ADDR_CMD &&
          wcmd.op == dis_pkg::OP_NEW_PACKET) begin
        packet_arg_out <= wcmd.arg;
      end
    end
  end

  assign recover_exit = mode == dis_pkg::MODE_RECOVER && pic_start_in &&
                        pic_decodable_in;
  assign scan_done = mode == dis_pkg::MODE_SCAN && i_found &&
                     decode_done_in && !stream_error_in;
  // pause runs queued commands at once; otherwise only after a decode or a recovery exit
  assign exec = fifo_valid && !stream_error_in &&
                (mode == dis_pkg::MODE_PAUSE || draining);

  // drain window opens at picture completion outside recovery, or at a recovery exit
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      draining <= 1'b0;
    end else if (stream_error_in) begin
      draining <= 1'b0;
    end else if ((decode_done_in && mode != dis_pkg::MODE_RECOVER) ||
                 recover_exit) begin
      draining <= 1'b1;
    end else if (!fifo_valid || (exec && !fifo_in_ready)) begin
      draining <= fifo_valid;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask <= dis_pkg::MASK_RESET;
    end else if (exec && fifo_cmd.op == dis_pkg::OP_SET_MASK) begin
      mask <= fifo_cmd.arg;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode <= dis_pkg::MODE_PLAY;
      resume_mode <= dis_pkg::MODE_PLAY;
      i_found <= 1'b0;
    end else begin
      case (mode)
        dis_pkg::MODE_RECOVER: begin
          if (recover_exit) begin
            mode <= resume_mode;
          end
        end
        dis_pkg::MODE_SCAN: begin
          if (stream_error_in) begin
            mode <= dis_pkg::MODE_RECOVER;
            resume_mode <= dis_pkg::MODE_SCAN;
          end else if (scan_done) begin
            mode <= dis_pkg::MODE_PAUSE;
          end else if (pic_start_in && pic_is_i_in) begin
            i_found <= 1'b1;
          end else if (exec && fifo_cmd.op == dis_pkg::OP_PLAY) begin
            mode <= dis_pkg::MODE_PLAY;
          end
        end
        dis_pkg::MODE_PLAY, dis_pkg::MODE_PAUSE: begin
          if (stream_error_in) begin
            mode <= dis_pkg::MODE_RECOVER;
            resume_mode <= dis_pkg::MODE_PLAY;
          end else if (exec && fifo_cmd.op == dis_pkg::OP_SCAN) begin
            mode <= dis_pkg::MODE_SCAN;
            i_found <= 1'b0;
          end else if (exec && fifo_cmd.op == dis_pkg::OP_PLAY) begin
            mode <= dis_pkg::MODE_PLAY;
          end
        end
        default: begin
          mode <= dis_pkg::MODE_PLAY;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      consume_en_out <= 1'b1;
      fast_scan_out <= 1'b0;
      discard_out <= 1'b0;
    end else begin
      consume_en_out <= mode != dis_pkg::MODE_PAUSE;
      fast_scan_out <= mode == dis_pkg::MODE_SCAN && !i_found;
      // headers still parse; only picture data is thrown away
      discard_out <= mode == dis_pkg::MODE_SCAN && !i_found &&
                     !(pic_start_in && pic_is_i_in);
    end
  end

  // fullness is refreshed at every row end, whatever the mask
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fullness <= dis_pkg::FULLNESS_RESET;
    end else if (row_end_in) begin
      fullness <= buffer_level_in;
    end
  end

  always_comb begin
    imm_events = 16'h0000;
    imm_events[dis_pkg::ST_ERR] = stream_error_in &&
                                  mask[dis_pkg::ST_ERR];
    imm_events[dis_pkg::ST_PIC] = vsync_in && first_field_in &&
                                  mask[dis_pkg::ST_PIC];
    imm_events[dis_pkg::ST_SCN] = scan_done &&
                                  mask[dis_pkg::ST_SCN];
  end

  // during recovery these keep firing every row while conditions hold
  always_comb begin
    row_events = 16'h0000;
    row_events[dis_pkg::ST_UND] = buffer_empty_in &&
                                  mask[dis_pkg::ST_UND];
    row_events[dis_pkg::ST_RDY] = ready_cond_in &&
                                  mask[dis_pkg::ST_RDY];
  end

  // host releases the line first, then clears status
  dis_irq_issue u_irq (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .imm_events_in(imm_events),
    .row_end_in(row_end_in),
    .row_events_in(row_events),
    .status_we_in(wr && paddr == dis_pkg::ADDR_STATUS),
    .status_wdata_in(pwdata[15:0]),
    .line_we_in(wr && paddr == dis_pkg::ADDR_CTRL),
    .line_wdata_in(pwdata[dis_pkg::CTRL_LINE_BIT]),
    .status_out(status),
    .pending_out(pending),
    .int_n_out(int_n_out)
  );
endmodule : dis_sequencer

//--- pkg/dis_pkg.sv
/*
  shared constants and types of the decoder interrupt sequencer.
  assumes an apb bus with 32-bit data; offsets are byte addresses.
*/
package dis_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FULLNESS = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0c;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_STATE = 8'h14;
  localparam int CTRL_LINE_BIT = 0;
  localparam int ST_ERR = 0;
  localparam int ST_PIC = 1;
  localparam int ST_UND = 8;
  localparam int ST_RDY = 10;
  localparam int ST_SCN = 11;
  localparam int CMD_OP_LSB = 16;
  localparam int STATE_DRAIN_BIT = 2;
  localparam int STATE_OVF_BIT = 3;
  localparam int STATE_PEND_LSB = 16;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] FULLNESS_RESET = 16'h0000;
  localparam logic LINE_RESET = 1'b1;
  localparam int CMD_FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_SET_MASK = 3'b001,
    OP_SCAN = 3'b010,
    OP_PLAY = 3'b011,
    OP_FLUSH = 3'b100,
    OP_NEW_PACKET = 3'b101
  } dis_op_t;

  typedef struct packed {
    dis_op_t op;
    logic [15:0] arg;
  } dis_cmd_t;

  typedef enum logic [1:0] {
    MODE_PLAY = 2'b00,
    MODE_SCAN = 2'b01,
    MODE_PAUSE = 2'b10,
    MODE_RECOVER = 2'b11
  } dis_mode_t;
endpackage : dis_pkg

//--- verilog/dis_fifo.sv
/*
  small synchronous fifo with valid/ready on both sides.
  assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
module dis_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  logic empty;
  logic full;

  assign empty = wr_ptr == rd_ptr;
  assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
                (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem[rd_ptr[AW-1:0]];
  assign push = in_valid_in && !full;
  assign pop = out_ready_in && !empty;

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : dis_fifo

//--- verilog/dis_irq_issue.sv
/*
  interrupt status word, pending queue and the active-low host line.
  assumes one-cycle event pulses and host write strobes from the bus.
*/
`timescale 1ns/1ns
module dis_irq_issue (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [15:0] imm_events_in,
  input wire logic row_end_in,
  input wire logic [15:0] row_events_in,
  input wire logic status_we_in,
  input wire logic [15:0] status_wdata_in,
  input wire logic line_we_in,
  input wire logic line_wdata_in,
  output logic [15:0] status_out,
  output logic [15:0] pending_out,
  output logic int_n_out
);
  logic status_zero;
  logic [15:0] cand;
  logic issue;

  assign status_zero = status_out == '0;
  // queued events leave only at a display-time check
  assign cand = row_end_in ?
                (pending_out | imm_events_in | row_events_in) :
                imm_events_in;
  assign issue = status_zero && (cand != '0);

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_out <= dis_pkg::STATUS_RESET;
    end else if (issue) begin
      // coinciding events go out as one physical interrupt
      status_out <= cand; // set wins over a host write
    end else if (status_we_in) begin
      status_out <= status_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pending_out <= '0;
    end else if (issue && row_end_in) begin
      pending_out <= '0;
    end else if (!issue) begin
      // held even if the host already let the line go
      pending_out <= pending_out | imm_events_in |
                     (row_end_in ? row_events_in : 16'h0000);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      int_n_out <= dis_pkg::LINE_RESET;
    end else if (issue) begin
      int_n_out <= 1'b0;
    end else if (line_we_in) begin
      int_n_out <= line_wdata_in;
    end
  end
endmodule : dis_irq_issue

//--- verification/dis_sequencer_assertions.sv
/*
  port-level checks of dis_sequencer.
  assumes one clock domain; bound at the foot of this file.
*/
`timescale 1ns/1ns
module dis_chk #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stream_error_in,
  input wire logic pic_start_in,
  input wire logic pic_is_i_in,
  input wire logic decode_done_in,
  input wire logic vsync_in,
  input wire logic row_end_in,
  input wire logic int_n_out,
  input wire logic consume_en_out,
  input wire logic fast_scan_out,
  input wire logic flush_stream_out,
  input wire logic new_packet_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence wr_acc;
    psel && penable && pready && pwrite;
  endsequence
  sequence cmd_acc(logic [2:0] op);
    wr_acc ##0 (paddr == dis_pkg::ADDR_CMD && pwdata[18:16] == op);
  endsequence
  property cmd_pulse(logic [2:0] op, logic q);
    cmd_acc(op) |=> ##[0:1] q ##1 !q;
  endproperty
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no access answer after setup");
  bad_addr_a: assert property (psel && penable && pready &&
    paddr[1:0] == 2'b00 |-> pslverr == (paddr > dis_pkg::ADDR_STATE))
    else $error("error response does not match address map");
  flush_pulse_a: assert property (
    cmd_pulse(dis_pkg::OP_FLUSH, flush_stream_out))
    else $error("flush pulse missing or too long");
  packet_pulse_a: assert property (
    cmd_pulse(dis_pkg::OP_NEW_PACKET, new_packet_out))
    else $error("new packet pulse missing or too long");
  line_fall_a: assert property (
    $fell(int_n_out) |-> $past(stream_error_in || vsync_in ||
      row_end_in || decode_done_in || (psel && penable && pwrite &&
      paddr == dis_pkg::ADDR_CTRL && !pwdata[0])))
    else $error("line asserted without a cause");
  line_rise_a: assert property (
    $rose(int_n_out) |-> $past(psel && penable && pwrite &&
      paddr == dis_pkg::ADDR_CTRL && pwdata[0]))
    else $error("line released by the device itself");
  pause_entry_a: assert property (
    $fell(consume_en_out) |-> $past(decode_done_in, 2))
    else $error("pause entered without decode completion");
  scan_consume_a: assert property (
    fast_scan_out |-> consume_en_out)
    else $error("fast scan without consumption");
  scan_i_found_a: assert property (
    fast_scan_out && pic_start_in && pic_is_i_in && !stream_error_in
    |-> ##2 !fast_scan_out)
    else $error("fast scan kept after intra picture start");
endmodule : dis_chk

bind dis_sequencer dis_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_dis_chk (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .stream_error_in(stream_error_in),
  .pic_start_in(pic_start_in), .pic_is_i_in(pic_is_i_in),
  .decode_done_in(decode_done_in), .vsync_in(vsync_in),
  .row_end_in(row_end_in), .int_n_out(int_n_out),
  .consume_en_out(consume_en_out), .fast_scan_out(fast_scan_out),
  .flush_stream_out(flush_stream_out), .new_packet_out(new_packet_out));

//--- verification/dis_host.sv
/*
  host processor model: apb master and interrupt service sequence.
  assumes the bench calls its tasks from one process at a time.
*/
`timescale 1ns/1ns
module dis_host (
  input wire logic clk_sys_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in
);
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk_sys_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_sys_in);
    penable_out <= 1'b1;
    do @(posedge clk_sys_in); while (pready_in !== 1'b1);
    q = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // idle bus is scrambled so a stale value cannot pass
    paddr_out <= ~a;
    pwdata_out <= ~d;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask : wr

  // line first: the device leaves the line alone while status is set
  task automatic service(output logic [31:0] st);
    logic e;
    xfer(1'b0, dis_pkg::ADDR_STATUS, 32'h0, st, e);
    wr(dis_pkg::ADDR_CTRL, 32'h1);
    wr(dis_pkg::ADDR_STATUS, 32'h0);
  endtask : service
endmodule : dis_host

//--- verification/decoder_interrupt_sequencer_test.sv
/*
  self-checking bench of dis_sequencer driven through the host model.
  assumes package, design, host model and checker compiled before it.
*/
`timescale 1ns/1ns
module decoder_interrupt_sequencer_test;
  logic clk_sys_in, rst_n_in, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0] ev;
  logic is_i, dec, ff, emp, rdy, int_n, consume, fscan, discard;
  logic flush, newpkt;
  logic [15:0] lvl, parg;
  int err_total = 0, tests_run = 0, n_flush = 0, n_pkt = 0;

  dis_sequencer #(.FIFO_DEPTH(4)) i_dis_sequencer (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stream_error_in(ev[0]), .pic_start_in(ev[1]), .pic_is_i_in(is_i),
    .pic_decodable_in(dec), .decode_done_in(ev[2]), .vsync_in(ev[3]),
    .first_field_in(ff), .row_end_in(ev[4]), .buffer_level_in(lvl),
    .buffer_empty_in(emp), .ready_cond_in(rdy), .int_n_out(int_n),
    .consume_en_out(consume), .fast_scan_out(fscan),
    .discard_out(discard), .flush_stream_out(flush),
    .new_packet_out(newpkt), .packet_arg_out(parg));
  dis_host i_dis_host (
    .clk_sys_in(clk_sys_in), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
    .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  // pulses last one cycle, so they are counted rather than sampled
  always @(posedge clk_sys_in) begin
    if (flush === 1'b1) n_flush++;
    if (newpkt === 1'b1) n_pkt++;
  end

  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rc(input string n, input logic [7:0] a,
    input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    logic x;
    i_dis_host.xfer(1'b0, a, 32'h0, q, x);
    chk(n, q & m, e);
  endtask : rc
  task automatic pulse(input int k);
    @(posedge clk_sys_in);
    ev[k] <= 1'b1;
    @(posedge clk_sys_in);
    ev <= '0;
    @(posedge clk_sys_in);
  endtask : pulse
  task automatic cmd(input dis_pkg::dis_op_t op, input logic [15:0] a);
    i_dis_host.wr(dis_pkg::ADDR_CMD, {13'h0, op, a});
  endtask : cmd

  task automatic t_reset;
    logic [31:0] q;
    logic e;
    rc("ctrl", dis_pkg::ADDR_CTRL, '1, 32'h1);
    rc("status", dis_pkg::ADDR_STATUS, '1, 32'h0);
    rc("mask", dis_pkg::ADDR_MASK, '1, 32'h0);
    i_dis_host.xfer(1'b1, 8'h18, 32'h5, q, e);
    chk("unmapped", 32'(e), 32'h1);
  endtask : t_reset

  task automatic t_error;
    logic [31:0] q;
    cmd(dis_pkg::OP_SET_MASK, 16'h0503);
    rc("mask early", dis_pkg::ADDR_MASK, '1, 32'h0);
    pulse(2);
    rc("mask", dis_pkg::ADDR_MASK, '1, 32'h0503);
    pulse(0);
    chk("err line", 32'(int_n), 32'h0);
    rc("recover", dis_pkg::ADDR_STATE, 32'h3, 32'h3);
    i_dis_host.service(q);
    chk("err status", q, 32'h1);
  endtask : t_error

  task automatic t_recover;
    logic [31:0] q;
    @(posedge clk_sys_in);
    emp <= 1'b1;
    rdy <= 1'b1;
    lvl <= 16'h1234;
    pulse(4);
    chk("row line", 32'(int_n), 32'h0);
    i_dis_host.service(q);
    chk("row status", q, 32'h0500);
    rc("fullness", dis_pkg::ADDR_FULLNESS, '1, 32'h1234);
    pulse(4);
    i_dis_host.wr(dis_pkg::ADDR_CTRL, 32'h1);
    pulse(4);
    chk("line held", 32'(int_n), 32'h1);
    rc("queue", dis_pkg::ADDR_STATE, 32'hffff0000, 32'h05000000);
    emp <= 1'b0;
    rdy <= 1'b0;
    cmd(dis_pkg::OP_SET_MASK, 16'h0902);
    i_dis_host.wr(dis_pkg::ADDR_STATUS, 32'h0);
    pulse(4);
    i_dis_host.service(q);
    chk("queued", q, 32'h0500);
    pulse(2);
    rc("mask held", dis_pkg::ADDR_MASK, '1, 32'h0503);
    dec <= 1'b1;
    pulse(1);
    rc("resume", dis_pkg::ADDR_STATE, 32'h3, 32'h0);
    rc("mask run", dis_pkg::ADDR_MASK, '1, 32'h0902);
    ff <= 1'b1;
    pulse(3);
    i_dis_host.service(q);
    chk("display", q, 32'h0002);
  endtask : t_recover

  task automatic t_scan;
    logic [31:0] q;
    cmd(dis_pkg::OP_SCAN, 16'h0);
    rc("still play", dis_pkg::ADDR_STATE, 32'h3, 32'h0);
    pulse(2);
    rc("scan", dis_pkg::ADDR_STATE, 32'h3, 32'h1);
    chk("fast", 32'(fscan), 32'h1);
    pulse(1);
    chk("skip", 32'(discard), 32'h1);
    is_i <= 1'b1;
    pulse(1);
    // flag flops follow mode one edge later
    @(posedge clk_sys_in);
    chk("i found", 32'(fscan), 32'h0);
    pulse(2);
    @(posedge clk_sys_in);
    chk("paused", 32'(consume), 32'h0);
    i_dis_host.service(q);
    chk("scan done", q, 32'h0800);
    cmd(dis_pkg::OP_SCAN, 16'h0);
    for (int i = 0; i < 8 && consume !== 1'b1; i++) @(posedge clk_sys_in);
    rc("rescan", dis_pkg::ADDR_STATE, 32'h3, 32'h1);
  endtask : t_scan

  task automatic t_cmds;
    cmd(dis_pkg::OP_FLUSH, 16'h0);
    cmd(dis_pkg::OP_NEW_PACKET, 16'hbeef);
    cmd(dis_pkg::OP_NOP, 16'h0);
    chk("flush", n_flush, 32'h1);
    chk("packet", n_pkt, 32'h1);
    chk("packet arg", 32'(parg), 32'hbeef);
  endtask : t_cmds

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (5000) @(posedge clk_sys_in);
    err_total++;
    complete_run;
  end

  initial begin
    rst_n_in = 1'b0;
    ev = '0;
    {is_i, dec, ff, emp, rdy} = '0;
    lvl = 16'h0;
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_reset;
    t_error;
    t_recover;
    t_scan;
    t_cmds;
    complete_run;
  end
endmodule : decoder_interrupt_sequencer_test
